// [shared/dvc_pkg.sv]
// Constants and types for the dual voice codec datapath
package dvc_pkg;
  localparam logic [4:0] IDX_CTL1 = 5'h01;
  localparam logic [4:0] IDX_AGAIN1 = 5'h03;
  localparam logic [4:0] IDX_DGAIN1 = 5'h04;
  localparam logic [4:0] IDX_CTL2 = 5'h06;
  localparam logic [4:0] IDX_AGAIN2 = 5'h08;
  localparam logic [4:0] IDX_DGAIN2 = 5'h09;
  localparam logic [4:0] IDX_XPT1 = 5'h0a;
  localparam logic [4:0] IDX_XPT2 = 5'h0b;
  localparam logic [4:0] IDX_MUTE = 5'h0c;
  localparam logic [4:0] IDX_HPF1 = 5'h0f;
  localparam logic [4:0] IDX_HPF2 = 5'h10;
  localparam int CTL_COMP = 0;
  localparam int CTL_ALAW = 1;
  localparam int CTL_DLB = 2;
  localparam int CTL_ALB = 3;
  localparam int CTL_EN = 4;
  localparam int HPF_BYP = 0;
  localparam int HPF_OVF = 1;
  localparam int XPT_LINE = 4;
  localparam logic [4:0] CTL_RST = 5'h10;
  localparam logic [5:0] GAIN_MAX = 6'h20;
  localparam logic [5:0] GAIN_RST = 6'h18;
  localparam logic [7:0] XPT_RST = 8'h00;
  localparam logic [7:0] MUTE_RST = 8'h00;
  localparam int CLK_KHZ = 200000;
  localparam int OS_KHZ = 1024;
  localparam logic [7:0] OS_DIV = 8'(CLK_KHZ / OS_KHZ);
  localparam int OSR_LOG = 7;
  localparam int ADC_SHIFT = 7;
  localparam int HPF_SHIFT = 6;
  localparam logic [5:0] SLOT_LAST = 6'h0f;
  localparam logic [5:0] FRAME_LAST = 6'h1f;
  localparam logic [5:0] FRAME_END = 6'h20;
  localparam logic [14:0] ADC_MAX = 15'h3fff;
  localparam logic [14:0] ADC_MIN = 15'h4000;
  typedef struct packed {
    logic bclk;
    logic frame_sync;
    logic din;
  } dvc_ser_in_t;
  typedef struct packed {
    logic dout;
    logic dout_oe_n;
  } dvc_ser_out_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dvc_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } dvc_wb_rsp_t;
  typedef struct packed {
    logic [1:0][5:0] adc_gain;
    logic [1:0][5:0] dac_gain;
    logic [1:0][7:0] xpt;
    logic [7:0] mute;
    logic [1:0] dac_mod;
  } dvc_ana_t;
endpackage : dvc_pkg

// [core/dvc_core.sv]
// Serial sample port, filters, companding and control registers
`timescale 1ns/1ps
module dvc_core import dvc_pkg::*; (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire dvc_ser_in_t ser_i,
  input wire logic [1:0] adc_mod_i,
  input wire dvc_wb_req_t wb_i,
  output dvc_wb_rsp_t wb_o,
  output dvc_ser_out_t ser_o,
  output dvc_ana_t ana_o
);
  typedef struct packed {
    logic [1:0] bclk_s;
    logic [1:0] fs_s;
    logic [1:0] din_s;
    logic [1:0][1:0] mod_s;
    logic bclk_q;
    logic [7:0] os_cnt;
    logic [1:0][4:0] ctl;
    logic [1:0] hpf_byp;
    logic [1:0] ovf;
    logic [1:0][15:0] acc;
    logic [1:0][15:0] dc;
    logic [1:0][14:0] adc_w;
    logic [1:0] valid;
    logic act;
    logic rx_act;
    logic [5:0] rise_cnt;
    logic [5:0] fall_cnt;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic [1:0][15:0] dac_cur;
    logic [1:0][15:0] dac_step;
    logic [1:0][15:0] sd_acc;
    dvc_ser_out_t ser;
    dvc_wb_rsp_t wb;
    dvc_ana_t ana;
  } dvc_state_t;

  dvc_state_t s_reg;
  dvc_state_t s_next;

  // Companding encoder, 16-bit linear in
  function automatic logic [7:0] dvc_enc(input logic [15:0] x, input logic alaw);
    logic [15:0] m;
    logic [2:0] e;
    logic [3:0] q;
    m = x[15] ? (~x + 16'h0001) : x;
    e = 3'h0;
    if (alaw) begin
      m = m >> 3;
      if (m > 16'h0fff) begin
        m = 16'h0fff;
      end
      for (int i = 1; i < 8; i++) begin
        if (m[i + 4]) begin
          e = 3'(i);
        end
      end
      q = 4'(m >> ((e == 3'h0) ? 1 : int'(e)));
      dvc_enc = {~x[15], e, q} ^ 8'h55;
    end else begin
      m = m >> 2;
      if (m > 16'h1fde) begin
        m = 16'h1fde;
      end
      m = m + 16'h0021;
      for (int i = 0; i < 8; i++) begin
        if (m[i + 5]) begin
          e = 3'(i);
        end
      end
      q = 4'(m >> (int'(e) + 1));
      dvc_enc = ~{x[15], e, q};
    end
  endfunction : dvc_enc

  // Companding decoder, 16-bit linear out
  function automatic logic [15:0] dvc_dec(input logic [7:0] c, input logic alaw);
    logic [7:0] v;
    logic [15:0] t;
    v = alaw ? (c ^ 8'h55) : ~c;
    t = {8'h00, v[3:0], 4'h0};
    if (alaw) begin
      if (v[6:4] == 3'h0) begin
        t = t + 16'h0008;
      end else begin
        t = (t + 16'h0108) << (v[6:4] - 3'h1);
      end
      dvc_dec = v[7] ? t : (~t + 16'h0001);
    end else begin
      t = ((t >> 1) + 16'h0084) << v[6:4];
      t = t - 16'h0084;
      dvc_dec = v[7] ? (~t + 16'h0001) : t;
    end
  endfunction : dvc_dec

  // Outgoing slot word for one codec
  function automatic logic [15:0] dvc_txw(input dvc_state_t s, input int c);
    if (s.ctl[c][CTL_COMP]) begin
      dvc_txw = {s.valid[c], 7'h00, dvc_enc({s.adc_w[c], 1'b0}, s.ctl[c][CTL_ALAW])};
    end else begin
      dvc_txw = {s.valid[c], s.adc_w[c]};
    end
  endfunction : dvc_txw

  logic rise;
  logic fall;
  logic frame;
  logic os_en;
  logic hit;
  logic [4:0] idx;
  logic [16:0] sum;
  logic [15:0] raw;
  logic [15:0] hp;
  logic [15:0] rxw;
  logic [15:0] tgt;
  logic [14:0] word;
  // Overflow raised this cycle; beats a clear
  logic [1:0] ovf_set;

  always_comb begin
    s_next = s_reg;
    sum = 17'h00000;
    raw = 16'h0000;
    hp = 16'h0000;
    rxw = 16'h0000;
    tgt = 16'h0000;
    word = 15'h0000;
    ovf_set = 2'b00;
    s_next.bclk_s = {s_reg.bclk_s[0], ser_i.bclk};
    s_next.fs_s = {s_reg.fs_s[0], ser_i.frame_sync};
    s_next.din_s = {s_reg.din_s[0], ser_i.din};
    for (int c = 0; c < 2; c++) begin
      s_next.mod_s[c] = {s_reg.mod_s[c][0], adc_mod_i[c]};
    end
    s_next.bclk_q = s_reg.bclk_s[1];
    rise = s_reg.bclk_s[1] & ~s_reg.bclk_q;
    fall = ~s_reg.bclk_s[1] & s_reg.bclk_q;
    frame = rise & s_reg.fs_s[1];
    os_en = (s_reg.os_cnt == OS_DIV - 8'h01);
    s_next.os_cnt = os_en ? 8'h00 : s_reg.os_cnt + 8'h01;

    for (int c = 0; c < 2; c++) begin
      // Decimation: integrate one-bit stream between frames
      if (os_en) begin
        if (s_reg.ctl[c][CTL_ALB] ? s_reg.ana.dac_mod[c] : s_reg.mod_s[c][1]) begin
          s_next.acc[c] = s_reg.acc[c] + 16'h0001;
        end else begin
          s_next.acc[c] = s_reg.acc[c] - 16'h0001;
        end
        s_next.dac_cur[c] = s_reg.dac_cur[c] + s_reg.dac_step[c];
        sum = {1'b0, s_reg.sd_acc[c]} + {1'b0, s_reg.dac_cur[c] ^ 16'h8000};
        s_next.sd_acc[c] = sum[15:0];
        s_next.ana.dac_mod[c] = sum[16];
      end
      if (frame) begin
        // Dump once per sample period, so the band follows the frame rate
        raw = 16'($signed(s_reg.acc[c]) <<< ADC_SHIFT);
        if ($signed(raw) >= $signed({1'b0, ADC_MAX})) begin
          word = ADC_MAX;
          s_next.ovf[c] = 1'b1;
          ovf_set[c] = 1'b1;
        end else if ($signed(raw) < $signed({1'b1, ADC_MIN})) begin
          word = ADC_MIN;
        end else begin
          word = raw[14:0];
        end
        hp = {word[14], word} - s_reg.dc[c];
        s_next.dc[c] = s_reg.dc[c] + 16'($signed(hp) >>> HPF_SHIFT);
        if (!s_reg.hpf_byp[c]) begin
          if ($signed(hp) > $signed({1'b0, ADC_MAX})) begin
            word = ADC_MAX;
          end else if ($signed(hp) < $signed({1'b1, ADC_MIN})) begin
            word = ADC_MIN;
          end else begin
            word = hp[14:0];
          end
        end
        s_next.adc_w[c] = word;
        s_next.valid[c] = s_reg.ctl[c][CTL_EN];
        s_next.acc[c] = 16'h0000;
      end
    end

    // Transmit on bit clock rise
    if (frame) begin
      s_next.act = 1'b1;
      s_next.rise_cnt = 6'h00;
      // Slot 0 takes this frame's dump, as slot 1 does
      s_next.tx_sh = dvc_txw(s_next, 0);
    end else if (rise && s_reg.act) begin
      if (s_reg.rise_cnt == FRAME_END) begin
        s_next.act = 1'b0;
        s_next.ser.dout_oe_n = 1'b1;
        s_next.ser.dout = 1'b0;
      end else begin
        s_next.ser.dout = s_reg.tx_sh[15];
        s_next.ser.dout_oe_n = 1'b0;
        s_next.tx_sh = {s_reg.tx_sh[14:0], 1'b0};
        s_next.rise_cnt = s_reg.rise_cnt + 6'h01;
        if (s_reg.rise_cnt == 6'h00) begin
          s_next.rx_act = 1'b1;
          s_next.fall_cnt = 6'h00;
        end
        if (s_reg.rise_cnt == SLOT_LAST) begin
          s_next.tx_sh = dvc_txw(s_reg, 1);
        end
      end
    end

    // Receive on bit clock fall
    if (fall && s_reg.rx_act) begin
      rxw = {s_reg.rx_sh[14:0], s_reg.din_s[1]};
      s_next.rx_sh = rxw;
      s_next.fall_cnt = s_reg.fall_cnt + 6'h01;
      for (int c = 0; c < 2; c++) begin
        if (s_reg.fall_cnt == (c == 0 ? SLOT_LAST : FRAME_LAST)) begin
          tgt = s_reg.ctl[c][CTL_COMP] ? dvc_dec(rxw[7:0], s_reg.ctl[c][CTL_ALAW]) : rxw;
          if (s_reg.ctl[c][CTL_DLB]) begin
            tgt = {s_reg.adc_w[c], 1'b0};
          end
          s_next.dac_step[c] = 16'($signed(tgt - s_reg.dac_cur[c]) >>> OSR_LOG);
        end
      end
      if (s_reg.fall_cnt == FRAME_LAST) begin
        s_next.rx_act = 1'b0;
      end
    end

    // Wishbone classic slave, one wait state
    hit = wb_i.cyc & wb_i.stb & ~s_reg.wb.ack;
    idx = wb_i.adr[6:2];
    s_next.wb.ack = hit;
    s_next.wb.dat = 32'h00000000;
    if (hit && !wb_i.we && wb_i.adr[7] == 1'b0) begin
      case (idx)
        IDX_CTL1: s_next.wb.dat = {27'h0, s_reg.ctl[0]};
        IDX_CTL2: s_next.wb.dat = {27'h0, s_reg.ctl[1]};
        IDX_AGAIN1: s_next.wb.dat = {26'h0, s_reg.ana.adc_gain[0]};
        IDX_AGAIN2: s_next.wb.dat = {26'h0, s_reg.ana.adc_gain[1]};
        IDX_DGAIN1: s_next.wb.dat = {26'h0, s_reg.ana.dac_gain[0]};
        IDX_DGAIN2: s_next.wb.dat = {26'h0, s_reg.ana.dac_gain[1]};
        IDX_XPT1: s_next.wb.dat = {24'h0, s_reg.ana.xpt[0]};
        IDX_XPT2: s_next.wb.dat = {24'h0, s_reg.ana.xpt[1]};
        IDX_MUTE: s_next.wb.dat = {24'h0, s_reg.ana.mute};
        IDX_HPF1: s_next.wb.dat = {30'h0, s_reg.ovf[0], s_reg.hpf_byp[0]};
        IDX_HPF2: s_next.wb.dat = {30'h0, s_reg.ovf[1], s_reg.hpf_byp[1]};
        default: s_next.wb.dat = 32'h00000000;
      endcase
    end
    // Writes need byte lane 0 and the lower half
    if (hit && wb_i.we && wb_i.sel[0] && wb_i.adr[7] == 1'b0) begin
      for (int c = 0; c < 2; c++) begin
        if (idx == (c == 0 ? IDX_CTL1 : IDX_CTL2)) begin
          s_next.ctl[c] = wb_i.dat[4:0];
        end
        if (idx == (c == 0 ? IDX_AGAIN1 : IDX_AGAIN2)) begin
          s_next.ana.adc_gain[c] = (wb_i.dat[5:0] > GAIN_MAX) ? GAIN_MAX : wb_i.dat[5:0];
        end
        if (idx == (c == 0 ? IDX_DGAIN1 : IDX_DGAIN2)) begin
          s_next.ana.dac_gain[c] = (wb_i.dat[5:0] > GAIN_MAX) ? GAIN_MAX : wb_i.dat[5:0];
        end
        if (idx == (c == 0 ? IDX_XPT1 : IDX_XPT2)) begin
          s_next.ana.xpt[c] = wb_i.dat[7:0];
          if (s_reg.ana.xpt[1 - c][XPT_LINE]) begin
            s_next.ana.xpt[c][XPT_LINE] = 1'b0;
          end
        end
        if (idx == (c == 0 ? IDX_HPF1 : IDX_HPF2)) begin
          s_next.hpf_byp[c] = wb_i.dat[HPF_BYP];
          // Write one clears the sticky flag
          if (wb_i.dat[HPF_OVF] && !ovf_set[c]) begin
            s_next.ovf[c] = 1'b0;
          end
        end
      end
      if (idx == IDX_MUTE) begin
        s_next.ana.mute = wb_i.dat[7:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s_reg <= '0;
      s_reg.ser.dout_oe_n <= 1'b1;
      s_reg.ctl <= {CTL_RST, CTL_RST};
      s_reg.ana.adc_gain <= {GAIN_RST, GAIN_RST};
      s_reg.ana.dac_gain <= {GAIN_RST, GAIN_RST};
      s_reg.ana.xpt <= {XPT_RST, XPT_RST};
      s_reg.ana.mute <= MUTE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_o = s_reg.wb;
  assign ser_o = s_reg.ser;
  assign ana_o = s_reg.ana;
endmodule : dvc_core

// [tb/dvc_core_props.sv]
// Port checker for the codec datapath
`timescale 1ns/1ps
module dvc_core_props import dvc_pkg::*; (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire dvc_ser_in_t ser_i,
  input wire logic [1:0] adc_mod_i,
  input wire dvc_wb_req_t wb_i,
  input wire dvc_wb_rsp_t wb_o,
  input wire dvc_ser_out_t ser_o,
  input wire dvc_ana_t ana_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence s_req;
    wb_i.cyc && wb_i.stb && !wb_o.ack;
  endsequence
  sequence s_wr_gain;
    s_req ##0 wb_i.we && wb_i.sel[0] && wb_i.adr == {1'b0, IDX_AGAIN1, 2'b00} && wb_i.dat[5:0] <= GAIN_MAX;
  endsequence
  sequence s_tx_on;
    $fell(ser_o.dout_oe_n);
  endsequence
  property p_ack;
    s_req |=> wb_o.ack ##1 !wb_o.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a pulse after request");
  property p_idle_dat;
    !wb_o.ack |-> wb_o.dat == 32'h0;
  endproperty
  a_idle_dat: assert property (p_idle_dat) else $error("read data without ack");
  property p_gain_wr;
    s_wr_gain |=> ana_o.adc_gain[0] == $past(wb_i.dat[5:0]);
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("input gain not updated");
  property p_gain_max;
    ana_o.dac_gain[0] <= GAIN_MAX && ana_o.dac_gain[1] <= GAIN_MAX;
  endproperty
  a_gain_max: assert property (p_gain_max) else $error("output gain above range");
  property p_line_once;
    !(ana_o.xpt[0][XPT_LINE] && ana_o.xpt[1][XPT_LINE]);
  endproperty
  a_line_once: assert property (p_line_once) else $error("line output driven twice");
  property p_rst;
    disable iff (1'b0) !reset_n_i |=> ser_o.dout_oe_n && ana_o.xpt == '0 && ana_o.adc_gain[1] == GAIN_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_tx_hold;
    s_tx_on |-> !ser_o.dout_oe_n [*8];
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("data out released early");
  property p_dout_rise;
    !ser_o.dout_oe_n && $changed(ser_o.dout) |-> $past(ser_i.bclk, 2);
  endproperty
  a_dout_rise: assert property (p_dout_rise) else $error("data out changed off rising edge");
  property p_tx_end;
    $rose(ser_o.dout_oe_n) |-> $past(ser_i.bclk, 2);
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("data out released off rising edge");
endmodule : dvc_core_props

bind dvc_core dvc_core_props u_props (
  .mclk_i(mclk_i),
  .reset_n_i(reset_n_i),
  .ser_i(ser_i),
  .adc_mod_i(adc_mod_i),
  .wb_i(wb_i),
  .wb_o(wb_o),
  .ser_o(ser_o),
  .ana_o(ana_o)
);

// [tb/dvc_host_model.sv]
// Host serial port model: bit clock, frame sync, sample words
`timescale 1ns/1ps
module dvc_host_model import dvc_pkg::*; (
  input wire logic go_i,
  input wire logic [31:0] tx_i,
  input wire dvc_ser_out_t ser_i,
  output dvc_ser_in_t ser_o,
  output logic [31:0] rx_o,
  output logic done_o
);
  initial begin
    ser_o = '0;
    rx_o = '0;
    done_o = 1'b0;
  end
  // Clock stands low between frames
  always @(posedge go_i) begin
    done_o <= 1'b0;
    ser_o.frame_sync <= 1'b1;
    for (int k = 0; k <= 33; k++) begin
      ser_o.bclk <= 1'b1;
      if (k >= 1 && k <= 32) ser_o.din <= tx_i[32 - k];
      else ser_o.din <= ~ser_o.din;
      #32;
      ser_o.bclk <= 1'b0;
      ser_o.frame_sync <= 1'b0;
      if (k >= 1 && k <= 32) rx_o[32 - k] = ser_i.dout;
      #32;
    end
    done_o <= 1'b1;
  end
endmodule : dvc_host_model

// [tb/dvc_core_tb.sv]
// Self-checking bench for the codec datapath
`timescale 1ns/1ps
module dvc_core_tb;
  import dvc_pkg::*;
  logic mclk_i, reset_n_i, go, done, done_q;
  logic [1:0] adc_mod_i;
  logic [31:0] tx, rx, v;
  logic [63:0] e;
  logic [63:0] rd_q[$];
  logic [63:0] fr_q[$];
  dvc_ser_in_t ser_i;
  dvc_wb_req_t wb_i;
  dvc_wb_rsp_t wb_o;
  dvc_ser_out_t ser_o;
  dvc_ana_t ana_o;
  int errors = 0;
  int n_compared = 0;
  int r;
  logic [4:0] gx[4] = '{IDX_AGAIN1, IDX_DGAIN1, IDX_AGAIN2, IDX_DGAIN2};
  logic [4:0] ix[10] = '{IDX_CTL1, IDX_AGAIN1, IDX_DGAIN1, IDX_CTL2, IDX_AGAIN2, IDX_DGAIN2,
    IDX_XPT1, IDX_XPT2, IDX_MUTE, 5'h1f};
  logic [31:0] rv[10] = '{32'h10, 32'h18, 32'h18, 32'h10, 32'h18, 32'h18, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] md[3] = '{32'h10, 32'h11, 32'h13};
  dvc_core u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ser_i(ser_i), .adc_mod_i(adc_mod_i),
    .wb_i(wb_i), .wb_o(wb_o), .ser_o(ser_o), .ana_o(ana_o));
  dvc_host_model u_host (.go_i(go), .tx_i(tx), .ser_i(ser_o), .ser_o(ser_i), .rx_o(rx), .done_o(done));
  always #2.5 mclk_i = ~mclk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic wb(input logic we, input logic [4:0] idx, input logic [31:0] d);
    wb_i <= '{1'b1, 1'b1, we, {1'b0, idx, 2'b00}, 4'hf, d};
    do begin
      @(posedge mclk_i);
    end while (wb_o.ack !== 1'b1);
    wb_i <= '0;
    @(posedge mclk_i);
  endtask : wb
  task automatic rd(input logic [4:0] idx, input logic [31:0] x, input logic [31:0] m);
    rd_q.push_back({m, x});
    wb(1'b0, idx, 32'h0);
  endtask : rd
  task automatic frame(input logic [31:0] x, input logic [31:0] m, input logic [31:0] d);
    fr_q.push_back({m, x});
    tx <= d;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    do begin
      @(posedge mclk_i);
    end while (done !== 1'b1);
  endtask : frame
  // Result watcher
  always @(posedge mclk_i) begin
    done_q <= done;
    if (wb_o.ack === 1'b1 && !wb_i.we && rd_q.size() > 0) begin
      e = rd_q.pop_front();
      check(wb_o.dat & e[63:32], e[31:0]);
    end
    if (done && !done_q && fr_q.size() > 0) begin
      e = fr_q.pop_front();
      check(rx & e[63:32], e[31:0]);
    end
  end
  initial begin
    #400000;
    errors++;
    stop_test();
  end
  initial begin
    mclk_i = 1'b0;
    reset_n_i = 1'b0;
    wb_i = '0;
    go = 1'b0;
    tx = '0;
    r = $urandom(32'he61e21c5);
    adc_mod_i = 2'($urandom);
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (2000) @(posedge mclk_i);
    foreach (ix[i]) rd(ix[i], rv[i], '1);
    $display("test reset done");
    foreach (gx[i]) begin
      v = $urandom_range(32);
      wb(1'b1, gx[i], v);
      rd(gx[i], v, '1);
    end
    wb(1'b1, IDX_DGAIN1, 32'h3f);
    rd(IDX_DGAIN1, 32'h20, '1);
    wb(1'b1, IDX_XPT1, 32'h13);
    rd(IDX_XPT1, 32'h13, '1);
    wb(1'b1, IDX_XPT2, 32'h11);
    rd(IDX_XPT2, 32'h01, '1);
    v = $urandom_range(255);
    wb(1'b1, IDX_MUTE, v);
    rd(IDX_MUTE, v, '1);
    $display("test registers done");
    adc_mod_i <= 2'b11;
    wb(1'b1, IDX_HPF1, 32'h1);
    wb(1'b1, IDX_HPF2, 32'h1);
    rd(IDX_HPF1, 32'h1, 32'h1);
    foreach (md[i]) begin
      wb(1'b1, IDX_CTL1, md[i]);
      frame(32'h80008000, 32'h80008000, $urandom);
      frame(32'h80008000, i ? 32'hff008000 : 32'h80008000, $urandom);
    end
    $display("test formats done");
    repeat (26000) @(posedge mclk_i);
    frame(32'h8000bfff, 32'h8000ffff, $urandom);
    rd(IDX_HPF1, 32'h2, 32'h2);
    rd(IDX_HPF2, 32'h2, 32'h2);
    wb(1'b1, IDX_HPF2, 32'h3);
    rd(IDX_HPF2, 32'h1, 32'h3);
    wb(1'b1, IDX_CTL2, 32'h0);
    frame(32'h80000000, 32'h80000000, $urandom);
    frame(32'h80000000, 32'h80008000, $urandom);
    $display("test stream done");
    reset_n_i <= 1'b0;
    adc_mod_i <= 2'b00;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (2000) @(posedge mclk_i);
    rd(IDX_CTL1, 32'h10, '1);
    wb(1'b1, IDX_CTL1, 32'h18);
    repeat (26000) @(posedge mclk_i);
    frame(32'hf8000000, 32'hf8000000, $urandom);
    $display("test loopback done");
    stop_test();
  end
endmodule : dvc_core_tb
